// file: common/vector_pkg.sv
// Constants for the reset and interrupt vector placement block
package vector_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int NUM_IRQ   = 34;            // Sources, vector numbers 2 to 35
  localparam int PC_W      = 16;            // Program word address width
  localparam int IDX_W     = 6;             // Width of a source index

  // ****************************************************************
  // Fuse encoding
  // ****************************************************************
  localparam logic FUSE_UNPROGRAMMED = 1'b1;
  localparam logic FUSE_PROGRAMMED   = 1'b0;

  // ****************************************************************
  // Addresses
  // ****************************************************************
  localparam logic [PC_W-1:0] RESET_WORD     = 16'h0000; // Application reset entry
  localparam logic [PC_W-1:0] VEC_TABLE_BASE = 16'h0002; // First interrupt vector
  localparam logic [PC_W-1:0] NO_OFFSET      = 16'h0000; // Table left in low flash

  // Base word address of each source, index 0 is vector number 2
  localparam logic [PC_W-1:0] VEC_BASE [0:NUM_IRQ-1] = '{
    16'h0002, 16'h0004, 16'h0006,                       // External requests 0..2
    16'h0008, 16'h000a, 16'h000c, 16'h000e,             // Pin change 0..3
    16'h0010,                                           // Watchdog time-out
    16'h0012, 16'h0014, 16'h0016,                       // Timer two
    16'h0018, 16'h001a, 16'h001c, 16'h001e,             // Timer one
    16'h0020, 16'h0022, 16'h0024,                       // Timer zero
    16'h0026,                                           // Serial peripheral done
    16'h0028, 16'h002a, 16'h002c,                       // First serial port
    16'h002e, 16'h0030, 16'h0032, 16'h0034, 16'h0036,   // Comparator .. self-prog
    16'h0038, 16'h003a, 16'h003c,                       // Second serial port
    16'h003e, 16'h0040, 16'h0042, 16'h0044              // Timer three
  };

  // ****************************************************************
  // Source indices
  // ****************************************************************
  localparam int IDX_EXT_ZERO        = 0;
  localparam int IDX_PIN_CHANGE_ZERO = 3;
  localparam int IDX_WATCHDOG        = 7;
  localparam int IDX_TIMER_TWO_A     = 8;
  localparam int IDX_TIMER_ONE_CAP   = 11;
  localparam int IDX_TIMER_ZERO_A    = 15;
  localparam int IDX_SPI_DONE        = 18;
  localparam int IDX_ANALOG_COMP     = 22;
  localparam int IDX_SERIAL_ONE_RX   = 27;
  localparam int IDX_TIMER_THREE     = 30;

  // Sources without timer three present
  localparam logic [NUM_IRQ-1:0] MASK_NO_TIMER_THREE = 34'h0_3fff_ffff;
  localparam logic [NUM_IRQ-1:0] MASK_ALL            = 34'h3_ffff_ffff;

  // Dispatcher states
  typedef enum logic [1:0] {
    ST_STRAP,
    ST_RESET_VEC,
    ST_IDLE,
    ST_SERVICE
  } disp_state_t;

endpackage

// file: rtl/vector_placement.sv
// Reset and interrupt vector address generator for the core fetch path
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Fuse unprogrammed: every reset starts execution at word zero.
// - Fuse programmed: reset loads the boot reset address instead.
// - Vector-select set: each vector is its base plus boot section start.
// - Default vectors begin at word two; relocated ones at boot address plus two.
// - Fuse value one is unprogrammed, zero programmed; independent of vector-select.
// - External requests zero to two use words two, four and six.
// - Pin change requests zero to three use words eight to fourteen, step two.
// - Watchdog time-out is vector nine at word sixteen.
// - Timer two: match A, match B, overflow at 0x12, 0x14, 0x16.
// - Timer one: capture, match A, match B, overflow at 0x18 to 0x1e.
// - Timer zero: match A, match B, overflow at 0x20, 0x22, 0x24.
// - Comparator, converter, data memory, two-wire, self-program at 0x2e to 0x36.
// - Second serial port receive, empty, transmit at 0x38, 0x3a, 0x3c.
// - Timer three vectors 0x3e to 0x44 exist only in that variant.
// - A source that is not enabled is never dispatched.
module vector_placement #(
  parameter bit HAS_TIMER_THREE = 1'b0               // Variant with timer three
) (
  input  wire logic                          sys_clk,              // System clock
  input  wire logic                          reset_n,              // Async reset, low
  input  wire logic                          boot_reset_fuse,      // 1 unprogrammed
  input  wire logic                          vector_table_in_boot, // Vector-select bit
  input  wire logic [vector_pkg::PC_W-1:0]   boot_reset_addr,      // Boot section start
  input  wire logic                          global_irq_enable,    // Core global enable
  input  wire logic [vector_pkg::NUM_IRQ-1:0] irq_req,             // Source requests
  input  wire logic [vector_pkg::NUM_IRQ-1:0] irq_enable,          // Source enables
  input  wire logic                          irq_return,           // Handler finished
  output logic                               pc_load,              // Load PC pulse
  output logic [vector_pkg::PC_W-1:0]        pc_load_addr,         // Word to load
  output logic [vector_pkg::NUM_IRQ-1:0]     irq_ack,              // One-hot granted
  output logic                               in_service            // Handler active
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  vector_pkg::disp_state_t state;
  vector_pkg::disp_state_t next_state;

  logic                               fuse_unprog;       // Fuse caught after release
  logic                               boot_relocated;    // Offset used by last load
  logic [vector_pkg::NUM_IRQ-1:0]     variant_mask;
  logic [vector_pkg::NUM_IRQ-1:0]     eligible;
  logic                               any_eligible;
  logic [vector_pkg::IDX_W-1:0]       win_idx;
  logic [vector_pkg::NUM_IRQ-1:0]     win_onehot;
  logic [vector_pkg::PC_W-1:0]        reset_target;
  logic [vector_pkg::PC_W-1:0]        table_offset;
  logic [vector_pkg::PC_W-1:0]        vector_target;
  logic                               next_pc_load;
  logic [vector_pkg::PC_W-1:0]        next_pc_load_addr;
  logic [vector_pkg::NUM_IRQ-1:0]     next_irq_ack;
  logic                               next_in_service;
  logic                               next_boot_relocated;

  // ****************************************************************
  // Source qualification and selection
  // ****************************************************************

  // Timer three slots are dead in the smaller variant
  assign variant_mask = HAS_TIMER_THREE ? vector_pkg::MASK_ALL
                                        : vector_pkg::MASK_NO_TIMER_THREE;

  // Only enabled, present sources compete
  assign eligible     = irq_req & irq_enable & variant_mask;
  assign any_eligible = global_irq_enable && (|eligible);

  // Scan downward so the lowest index is the last to win
  always_comb begin
    win_idx = '0;
    for (int i = vector_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        win_idx = vector_pkg::IDX_W'(i);
      end
    end
  end

  assign win_onehot = vector_pkg::NUM_IRQ'(1) << win_idx;

  // ****************************************************************
  // Address formation
  // ****************************************************************

  // Reset entry follows the fuse alone
  assign reset_target  = (fuse_unprog == vector_pkg::FUSE_UNPROGRAMMED)
                         ? vector_pkg::RESET_WORD
                         : boot_reset_addr;

  // Table offset follows the vector-select bit alone
  assign table_offset  = vector_table_in_boot ? boot_reset_addr
                                              : vector_pkg::NO_OFFSET;

  // Fixed base per source plus the relocation offset
  assign vector_target = vector_pkg::VEC_BASE[win_idx] + table_offset;

  // ****************************************************************
  // Dispatcher next state and outputs
  // ****************************************************************
  always_comb begin
    next_state          = state;
    next_pc_load        = 1'b0;
    next_pc_load_addr   = pc_load_addr;
    next_irq_ack        = '0;
    next_in_service     = in_service;
    next_boot_relocated = boot_relocated;
    case (state)
      vector_pkg::ST_STRAP: begin
        next_state = vector_pkg::ST_RESET_VEC;
      end
      vector_pkg::ST_RESET_VEC: begin
        next_pc_load        = 1'b1;
        next_pc_load_addr   = reset_target;
        next_boot_relocated = 1'b0;
        next_state          = vector_pkg::ST_IDLE;
      end
      vector_pkg::ST_IDLE: begin
        if (any_eligible) begin
          next_pc_load        = 1'b1;
          next_pc_load_addr   = vector_target;
          next_irq_ack        = win_onehot;
          next_in_service     = 1'b1;
          next_boot_relocated = vector_table_in_boot;
          next_state          = vector_pkg::ST_SERVICE;
        end
      end
      vector_pkg::ST_SERVICE: begin
        if (irq_return) begin
          next_in_service = 1'b0;
          next_state      = vector_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = vector_pkg::ST_STRAP;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Dispatcher state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= vector_pkg::ST_STRAP;
    end else begin
      state <= next_state;
    end
  end

  // Fuse strap caught in the first cycle after release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fuse_unprog <= vector_pkg::FUSE_UNPROGRAMMED;
    end else if (state == vector_pkg::ST_STRAP) begin
      fuse_unprog <= boot_reset_fuse;
    end
  end

  // Registered outputs toward the core
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_load        <= 1'b0;
      pc_load_addr   <= vector_pkg::RESET_WORD;
      irq_ack        <= '0;
      in_service     <= 1'b0;
      boot_relocated <= 1'b0;
    end else begin
      pc_load        <= next_pc_load;
      pc_load_addr   <= next_pc_load_addr;
      irq_ack        <= next_irq_ack;
      in_service     <= next_in_service;
      boot_relocated <= next_boot_relocated;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  // Unprogrammed fuse sends reset to word zero
  a_reset_app_entry: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (state == vector_pkg::ST_RESET_VEC && fuse_unprog == vector_pkg::FUSE_UNPROGRAMMED)
    |=> (pc_load && pc_load_addr == 16'h0000 && irq_ack == '0))
    else $error("reset load not at word zero");

  // Programmed fuse sends reset to the boot entry
  a_reset_boot_entry: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (state == vector_pkg::ST_RESET_VEC && fuse_unprog == vector_pkg::FUSE_PROGRAMMED)
    |=> (pc_load && pc_load_addr == $past(boot_reset_addr)))
    else $error("reset load not at boot address");

  // Fuse caught at release decides the first load two edges later
  a_fuse_strap_used: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (state == vector_pkg::ST_STRAP)
    |-> ##2 (pc_load && pc_load_addr ==
            ($past(boot_reset_fuse, 2) ? 16'h0000 : $past(boot_reset_addr))))
    else $error("reset entry does not follow fuse");

  // Relocated vectors carry the boot offset
  a_vec_relocated: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (state == vector_pkg::ST_IDLE && any_eligible && vector_table_in_boot)
    |=> (pc_load && boot_relocated && pc_load_addr ==
         vector_pkg::VEC_BASE[$past(win_idx)] + $past(boot_reset_addr)))
    else $error("relocated vector address wrong");

  // First vector sits at word two, or boot address plus two
  a_first_vector: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    irq_ack[0] |-> (pc_load_addr ==
                    (boot_relocated ? $past(boot_reset_addr) + 16'h0002 : 16'h0002)))
    else $error("first vector misplaced");

  // External request two at word six
  a_ext_two_addr: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (irq_ack[2] && !boot_relocated) |-> pc_load_addr == 16'h0006)
    else $error("external request two misplaced");

  // Last pin change vector at word fourteen
  a_pin_change_addr: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (irq_ack[6] && !boot_relocated) |-> pc_load_addr == 16'h000e)
    else $error("pin change three misplaced");

  // Watchdog vector at word sixteen
  a_watchdog_addr: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (irq_ack[vector_pkg::IDX_WATCHDOG] && !boot_relocated) |-> pc_load_addr == 16'h0010)
    else $error("watchdog vector misplaced");

  // Timer two overflow
  a_timer_two_addr: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (irq_ack[10] && !boot_relocated) |-> pc_load_addr == 16'h0016)
    else $error("timer two overflow misplaced");

  // Timer one match A
  a_timer_one_addr: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (irq_ack[12] && !boot_relocated) |-> pc_load_addr == 16'h001a)
    else $error("timer one match A misplaced");

  // Timer zero overflow
  a_timer_zero_addr: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (irq_ack[17] && !boot_relocated) |-> pc_load_addr == 16'h0024)
    else $error("timer zero overflow misplaced");

  // First serial port transmit complete
  a_serial_zero_addr: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (irq_ack[21] && !boot_relocated) |-> pc_load_addr == 16'h002c)
    else $error("first serial transmit misplaced");

  // Self-programming ready
  a_self_prog_addr: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (irq_ack[26] && !boot_relocated) |-> pc_load_addr == 16'h0036)
    else $error("self-program ready misplaced");

  // Second serial port receive complete
  a_serial_one_addr: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (irq_ack[vector_pkg::IDX_SERIAL_ONE_RX] && !boot_relocated)
    |-> pc_load_addr == 16'h0038)
    else $error("second serial receive misplaced");

  // Timer three absent unless the variant has it
  a_timer_three_gate: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (!HAS_TIMER_THREE) |-> (irq_ack[33:30] == 4'h0))
    else $error("timer three granted in small variant");

  // Grants go only to enabled, requesting sources
  a_grant_enabled: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (irq_ack != '0) |-> ((irq_ack & ~$past(irq_req & irq_enable)) == '0
                         && $past(global_irq_enable)))
    else $error("grant to a disabled source");

  // No lower pending source is passed over
  a_lowest_first: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (irq_ack != '0) |-> ($onehot(irq_ack)
                         && (((irq_ack - 34'h1) & $past(eligible)) == '0)))
    else $error("higher vector granted before lower");

  // One grant per handler: no new load while a handler stays active
  a_single_service: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (in_service && $past(in_service)) |-> !pc_load)
    else $error("second dispatch while in service");

endmodule

`default_nettype wire

// file: testbench/core_fetch_model.sv
// Behavioural model of the core fetch path that runs each interrupt handler
`timescale 1ns/100ps
`default_nettype none

module core_fetch_model (
  input  wire logic                           sys_clk,     // System clock
  input  wire logic                           reset_n,     // Async reset, low
  input  wire logic                           pc_load,     // Load PC pulse
  input  wire logic [vector_pkg::NUM_IRQ-1:0] irq_ack,     // Granted source
  input  wire logic [7:0]                     handler_len, // Handler cycles
  output logic                                irq_return   // Handler done pulse
);
  logic [7:0] remain;  // Cycles left in handler
  logic       running; // Handler in progress

  // ****************************************************************
  // Handler timing
  // ****************************************************************
  // A reset load carries no grant, so it starts no handler
  always @(negedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      running <= 1'b0;
      remain <= 8'h00;
      irq_return <= 1'b0;
    end else begin
      irq_return <= 1'b0;
      if (pc_load && (|irq_ack)) begin
        running <= 1'b1;
        remain <= handler_len;
      end else if (running && remain == 8'h00) begin
        running <= 1'b0;
        irq_return <= 1'b1;
      end else if (running) begin
        remain <= remain - 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the vector placement block
`timescale 1ns/100ps
`default_nettype none

module testbench;
  typedef logic [vector_pkg::NUM_IRQ-1:0] word_t;
  localparam logic [15:0] BOOT = 16'h7e00; // Boot section start

  logic        sys_clk     = 1'b0;
  logic        reset_n     = 1'b0;
  logic        fuse        = 1'b1;
  logic        vtib        = 1'b0;
  logic        gie         = 1'b1;
  word_t       irq_req     = '0;
  word_t       irq_enable  = '1;
  logic [7:0]  handler_len = 8'h01;
  logic        irq_return;
  logic        pc_load;
  logic [15:0] pc_load_addr;
  word_t       irq_ack;
  logic        in_service;
  int          cycles      = 0;
  int          fail_count  = 0;
  int          tests_run   = 0;

  // ****************************************************************
  // Clock, block and partner
  // ****************************************************************
  always #10 sys_clk = ~sys_clk;

  vector_placement u_vector_placement (
    .sys_clk              (sys_clk),
    .reset_n              (reset_n),
    .boot_reset_fuse      (fuse),
    .vector_table_in_boot (vtib),
    .boot_reset_addr      (BOOT),
    .global_irq_enable    (gie),
    .irq_req              (irq_req),
    .irq_enable           (irq_enable),
    .irq_return           (irq_return),
    .pc_load              (pc_load),
    .pc_load_addr         (pc_load_addr),
    .irq_ack              (irq_ack),
    .in_service           (in_service)
  );

  core_fetch_model u_core_fetch_model (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .pc_load     (pc_load),
    .irq_ack     (irq_ack),
    .handler_len (handler_len),
    .irq_return  (irq_return)
  );

  // ****************************************************************
  // Reporting
  // ****************************************************************
  task automatic check(input string what, input word_t seen, input word_t exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish;
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset, then flip the fuse after capture; the entry must not move
  task automatic do_reset(input logic fz, input logic [15:0] entry);
    @(negedge sys_clk);
    reset_n = 1'b0;
    fuse = fz;
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    @(posedge sys_clk);
    #1;
    check("pc_load edge one", word_t'(pc_load), '0);
    @(negedge sys_clk);
    fuse = ~fz;
    @(posedge sys_clk);
    #1;
    check("pc_load reset", word_t'(pc_load), 1);
    check("reset entry", word_t'(pc_load_addr), word_t'(entry));
    check("irq_ack reset", irq_ack, '0);
    @(posedge sys_clk);
    #1;
    check("pc_load edge three", word_t'(pc_load), '0);
    @(negedge sys_clk);
    fuse = fz;
  endtask

  // Wait for a dispatch, judge it, retire the source and the handler
  task automatic serve(input int idx, input logic [15:0] off, input int lat);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (pc_load !== 1'b1 && n < 20);
    check("pc_load", word_t'(pc_load), 1);
    if (lat != 0) check("dispatch latency", word_t'(n), word_t'(lat));
    check("pc_load_addr", word_t'(pc_load_addr),
          word_t'(off + 16'h0002 + 16'(2 * idx)));
    check("irq_ack", irq_ack, word_t'(1) << idx);
    @(negedge sys_clk);
    irq_req[idx] = 1'b0;
    n = 0;
    while (in_service === 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (in_service === 1'b1) check("pc_load in service", word_t'(pc_load), '0);
    end
    check("in_service", word_t'(in_service), '0);
  endtask

  task automatic single(input int idx, input logic [15:0] off);
    @(negedge sys_clk);
    irq_req[idx] = 1'b1;
    serve(idx, off, 1);
  endtask

  // Every source present in this variant, one at a time
  task automatic sweep(input logic [15:0] off);
    for (int i = 0; i < 30; i++) begin
      single(i, off);
    end
  endtask

  // Disabled, absent and globally blocked sources are never taken
  task automatic masked_sources;
    @(negedge sys_clk);
    irq_enable[3] = 1'b0;
    irq_req[3] = 1'b1;
    irq_req[31] = 1'b1;
    gie = 1'b0;
    irq_req[0] = 1'b1;
    repeat (10) begin
      @(posedge sys_clk);
      #1;
      check("pc_load masked", word_t'(pc_load), '0);
    end
    @(negedge sys_clk);
    gie = 1'b1;
    serve(0, 16'h0000, 1);
    single(10, 16'h0000);
    @(negedge sys_clk);
    irq_req = '0;
    irq_enable = '1;
  endtask

  // Three pending at once with a slow handler
  task automatic priority_order;
    handler_len = 8'h08;
    @(negedge sys_clk);
    irq_req = 34'h0_0010_1020;
    serve(5, 16'h0000, 1);
    serve(12, 16'h0000, 0);
    serve(20, 16'h0000, 0);
    @(negedge sys_clk);
    handler_len = 8'h01;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    do_reset(vector_pkg::FUSE_UNPROGRAMMED, 16'h0000);
    sweep(16'h0000);
    masked_sources;
    priority_order;
    @(negedge sys_clk);
    vtib = 1'b1;
    sweep(BOOT);
    @(negedge sys_clk);
    vtib = 1'b0;
    do_reset(vector_pkg::FUSE_PROGRAMMED, BOOT);
    single(7, 16'h0000);
    @(negedge sys_clk);
    vtib = 1'b1;
    single(7, BOOT);
    tally_and_finish;
  end
endmodule

`default_nettype wire
